/* rtl/pmc_cap_regs.sv */
// Power-management capability header and control/status low byte of one switch port.
// Assumes a single-cycle register port from the port's configuration logic, on the same clock.
`default_nettype none

// Contract
// - The capability identifier in bits 7:0 of the header always reads 0x1.
// - On the upstream port the next-capability pointer in bits 15:8 reads 0x0.
// - On the two downstream ports the next-capability pointer reads 0x7C.
// - The version field in bits 18:16 reads 0x2.
// - The event-clock bit 19 is read-only and reads zero.
// - The special-init bit 21 resets to zero and is writable only while the lockable path is open.
// - The auxiliary-current field in bits 24:22 reads zero.
// - The event-support field in bits 31:27 reads binary 11001.
// - Power-management event messages are not forwarded while the port is in D3 cold.
// - The power-state field in bits 1:0 of control/status is read/write, resets to D0, 0x0 is D0 and 0x3 D3 hot.
module pmc_cap_regs #(
	parameter bit UPSTREAM_PORT = 1'b0
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire pmc_pkg::pmc_req_type        req,
	output logic [pmc_pkg::DATA_WIDTH-1:0]   rdata,
	input  wire logic                        lock_write_open,
	input  wire logic                        in_d3_cold,
	input  wire logic                        event_in_valid,
	output logic                             event_fwd_valid,
	output pmc_pkg::pmc_power_state_type     power_state,
	output logic                             special_init
);
	import pmc_pkg::*;

	// ************************************************************
	// Decode
	// ************************************************************
	logic                  hit_cap_hdr;
	logic                  hit_ctrl_sts;
	logic [7:0]            next_ptr;
	logic [DATA_WIDTH-1:0] cap_hdr_word;
	logic [DATA_WIDTH-1:0] ctrl_sts_word;
	logic [DATA_WIDTH-1:0] read_mux;
	logic [1:0]            wr_state;

	pmc_power_state_type   power_state_reg;
	logic                  special_init_reg;
	logic [DATA_WIDTH-1:0] rdata_reg;
	logic                  event_fwd_reg;

	// Word-aligned compare; byte offset bits are don't-care
	assign hit_cap_hdr  = (req.addr[ADDR_WIDTH-1:2] == OFFSET_CAP_HDR[ADDR_WIDTH-1:2]);
	assign hit_ctrl_sts = (req.addr[ADDR_WIDTH-1:2] == OFFSET_CTRL_STS[ADDR_WIDTH-1:2]);
	assign wr_state     = req.wdata[POWER_STATE_LSB +: 2];

	assign next_ptr = UPSTREAM_PORT ? NEXT_PTR_UP : NEXT_PTR_DOWN;

	// ************************************************************
	// Read words
	// ************************************************************
	always_comb begin
		cap_hdr_word = '0;
		cap_hdr_word[CAP_ID_LSB +: 8]        = CAP_ID_VALUE;
		cap_hdr_word[NEXT_PTR_LSB +: 8]      = next_ptr;
		cap_hdr_word[VERSION_LSB +: 3]       = VERSION_VALUE;
		cap_hdr_word[EVENT_CLOCK_BIT]        = EVENT_CLOCK_VAL;
		cap_hdr_word[SPECIAL_INIT_BIT]       = special_init_reg;
		cap_hdr_word[AUX_CURRENT_LSB +: 3]   = AUX_CURRENT_VAL;
		cap_hdr_word[D1_SUPPORT_BIT]         = D1_SUPPORT_VAL;
		cap_hdr_word[D2_SUPPORT_BIT]         = D2_SUPPORT_VAL;
		cap_hdr_word[EVENT_STATES_LSB +: 5]  = EVENT_STATES_VAL;
	end

	always_comb begin
		ctrl_sts_word = '0;
		ctrl_sts_word[POWER_STATE_LSB +: 2] = power_state_reg;
	end

	always_comb begin
		if (hit_cap_hdr) begin
			read_mux = cap_hdr_word;
		end else if (hit_ctrl_sts) begin
			read_mux = ctrl_sts_word;
		end else begin
			read_mux = '0;
		end
	end

	// ************************************************************
	// Read data: valid only in the cycle after the strobe
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg <= '0;
		end else if (req.read) begin
			rdata_reg <= read_mux;
		end else begin
			rdata_reg <= '0;
		end
	end

	// ************************************************************
	// Power state
	// ************************************************************
	// Writes of the unsupported D1 and D2 codes are dropped so the port never sits in a state it cannot honour
	always_ff @(posedge clk) begin
		if (rst) begin
			power_state_reg <= pmc_power_state_type'(POWER_STATE_RST);
		end else if (req.write && hit_ctrl_sts) begin
			case (wr_state)
				PMC_STATE_D0:     power_state_reg <= PMC_STATE_D0;
				PMC_STATE_D3_HOT: power_state_reg <= PMC_STATE_D3_HOT;
				default:          power_state_reg <= power_state_reg;
			endcase
		end
	end

	// ************************************************************
	// Lockable special-init bit
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			special_init_reg <= SPECIAL_INIT_RST;
		end else if (req.write && hit_cap_hdr && lock_write_open) begin
			special_init_reg <= req.wdata[SPECIAL_INIT_BIT];
		end
	end

	// ************************************************************
	// Event forwarding
	// ************************************************************
	// Registered so the cut-off in D3 cold is clean at the output
	always_ff @(posedge clk) begin
		if (rst) begin
			event_fwd_reg <= 1'b0;
		end else begin
			event_fwd_reg <= event_in_valid && !in_d3_cold;
		end
	end

	assign rdata           = rdata_reg;
	assign event_fwd_valid = event_fwd_reg;
	assign power_state     = power_state_reg;
	assign special_init    = special_init_reg;

endmodule

`default_nettype wire

/* rtl/pmc_pkg.sv */
// Package for the power-management capability register bank.
// Assumes a 12-bit byte-addressed configuration space with 32-bit words.
`default_nettype none

package pmc_pkg;

	// ************************************************************
	// Bus geometry and register offsets
	// ************************************************************
	localparam int          ADDR_WIDTH      = 12;
	localparam int          DATA_WIDTH      = 32;
	localparam logic [11:0] OFFSET_CAP_HDR  = 12'h070;
	localparam logic [11:0] OFFSET_CTRL_STS = 12'h074;

	// ************************************************************
	// Capability header fields
	// ************************************************************
	localparam int          CAP_ID_LSB       = 0;
	localparam logic [7:0]  CAP_ID_VALUE     = 8'h01;
	localparam int          NEXT_PTR_LSB     = 8;
	localparam logic [7:0]  NEXT_PTR_UP      = 8'h00;
	localparam logic [7:0]  NEXT_PTR_DOWN    = 8'h7C;
	localparam int          VERSION_LSB      = 16;
	localparam logic [2:0]  VERSION_VALUE    = 3'h2;
	localparam int          EVENT_CLOCK_BIT  = 19;
	localparam logic        EVENT_CLOCK_VAL  = 1'b0;
	localparam int          SPECIAL_INIT_BIT = 21;
	localparam logic        SPECIAL_INIT_RST = 1'b0;
	localparam int          AUX_CURRENT_LSB  = 22;
	localparam logic [2:0]  AUX_CURRENT_VAL  = 3'h0;
	localparam int          D1_SUPPORT_BIT   = 25;
	localparam int          D2_SUPPORT_BIT   = 26;
	localparam logic        D1_SUPPORT_VAL   = 1'b0;
	localparam logic        D2_SUPPORT_VAL   = 1'b0;
	localparam int          EVENT_STATES_LSB = 27;
	localparam logic [4:0]  EVENT_STATES_VAL = 5'h19;

	// ************************************************************
	// Control/status fields
	// ************************************************************
	localparam int          POWER_STATE_LSB = 0;
	localparam logic [1:0]  POWER_STATE_RST = 2'h0;

	typedef enum logic [1:0] {
		PMC_STATE_D0     = 2'h0,
		PMC_STATE_D1     = 2'h1,
		PMC_STATE_D2     = 2'h2,
		PMC_STATE_D3_HOT = 2'h3
	} pmc_power_state_type;

	// ************************************************************
	// Register port request
	// ************************************************************
	typedef struct packed {
		logic [ADDR_WIDTH-1:0] addr;
		logic [DATA_WIDTH-1:0] wdata;
		logic                  write;
		logic                  read;
	} pmc_req_type;

endpackage

`default_nettype wire

/* tb/pmc_cap_regs_chk.sv */
// Assertions on the register port and event path of pmc_cap_regs.
// Bound to every instance, so both port flavours are watched.
`default_nettype none
module pmc_cap_regs_chk
	import pmc_pkg::*;
#(parameter bit UPSTREAM_PORT = 1'b0) (
	input wire logic                clk,
	input wire logic                rst,
	input wire pmc_req_type         req,
	input wire logic [31:0]         rdata,
	input wire logic                lock_write_open,
	input wire logic                in_d3_cold,
	input wire logic                event_in_valid,
	input wire logic                event_fwd_valid,
	input wire pmc_power_state_type power_state,
	input wire logic                special_init
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic hdr = req.addr[11:2] == OFFSET_CAP_HDR[11:2];
	wire logic csr = req.addr[11:2] == OFFSET_CTRL_STS[11:2];
	wire logic wen = req.write && hdr && lock_write_open;
	// ************************************************************
	// Read data, state and event gating
	// ************************************************************
	chk_header_value: assert property (req.read && hdr |=>
		rdata == {10'h320, $past(special_init), 5'h02, UPSTREAM_PORT ? 8'h00 : 8'h7C, 8'h01}) else $error("bad header");
	chk_status_value: assert property (req.read && csr |=> rdata == {30'h0, $past(power_state)})
		else $error("bad status");
	chk_idle_zero: assert property (!(req.read && (hdr || csr)) |=> rdata == 32'h0)
		else $error("read data not zero");
	chk_event_gate: assert property (event_in_valid |=> event_fwd_valid == !$past(in_d3_cold))
		else $error("event gating wrong");
	chk_state_write: assert property (req.write && csr && req.wdata[0] == req.wdata[1] |=>
		power_state == $past(req.wdata[1:0])) else $error("state not written");
	chk_state_keep: assert property (!(req.write && csr && req.wdata[0] == req.wdata[1]) |=> $stable(power_state))
		else $error("state changed");
	chk_init_locked: assert property (!wen |=> $stable(special_init))
		else $error("init bit changed");
	chk_init_write: assert property (wen |=> special_init == $past(req.wdata[21]))
		else $error("init bit not written");
endmodule
bind pmc_cap_regs pmc_cap_regs_chk #(.UPSTREAM_PORT(UPSTREAM_PORT)) i_pmc_cap_regs_chk (.clk(clk), .rst(rst), .req(req),
	.rdata(rdata), .lock_write_open(lock_write_open), .in_d3_cold(in_d3_cold), .event_in_valid(event_in_valid),
	.event_fwd_valid(event_fwd_valid), .power_state(power_state), .special_init(special_init));
`default_nettype wire

/* tb/test_pmc_cap_regs.sv */
// Self-checking bench for both flavours of pmc_cap_regs.
// Assumes the checker is bound from its own file.
`default_nettype none
module test_pmc_cap_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import pmc_pkg::*;
	logic                clk, rst, lock_write_open, in_d3_cold, event_in_valid, event_fwd_valid, special_init;
	logic [31:0]         rdata, rdata_up;
	pmc_req_type         req;
	pmc_power_state_type power_state;
	logic [1:0]          ps_exp;
	logic [1:0]          ps_seq[4] = '{2'h3, 2'h1, 2'h2, 2'h0};
	int                  errors = 0, samples_checked = 0, cycles = 0;
	pmc_cap_regs i_pmc_cap_regs (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .lock_write_open(lock_write_open),
		.in_d3_cold(in_d3_cold), .event_in_valid(event_in_valid), .event_fwd_valid(event_fwd_valid),
		.power_state(power_state), .special_init(special_init));
	// Upstream flavour shares every input, so only its pointer byte may differ
	pmc_cap_regs #(.UPSTREAM_PORT(1'b1)) i_pmc_cap_regs_up (.clk(clk), .rst(rst), .req(req), .rdata(rdata_up),
		.lock_write_open(lock_write_open), .in_d3_cold(in_d3_cold), .event_in_valid(event_in_valid),
		.event_fwd_valid(), .power_state(), .special_init());
	// ************************************************************
	// Bus tasks and closing
	// ************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req <= '0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		req <= '0;
		#1;
		chk(rdata, e);
		chk(rdata_up, a == OFFSET_CAP_HDR ? {e[31:16], 8'h00, e[7:0]} : e);
	endtask
	task automatic end_sim();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 500) begin
			errors++;
			end_sim();
		end
	end
	initial begin
		{rst, lock_write_open, in_d3_cold, event_in_valid, req} = {1'b1, 3'h0, 46'h0};
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(OFFSET_CAP_HDR, 32'hC8027C01);
		wr(OFFSET_CAP_HDR, 32'hFFFFFFFF);
		rd(OFFSET_CAP_HDR, 32'hC8027C01);
		@(posedge clk);
		lock_write_open <= 1'b1;
		wr(OFFSET_CAP_HDR, 32'hFFFFFFFF);
		lock_write_open <= 1'b0;
		wr(OFFSET_CAP_HDR, 32'h0);
		rd(OFFSET_CAP_HDR, 32'hC8227C01);
		chk(special_init, 32'h1);
		// Mid-run reset must clear both writable fields
		wr(OFFSET_CTRL_STS, 32'h3);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(OFFSET_CAP_HDR, 32'hC8027C01);
		chk(special_init, 32'h0);
		rd(OFFSET_CTRL_STS, 32'h0);
		chk(power_state, 32'h0);
		ps_exp = 2'h0;
		foreach (ps_seq[i]) begin
			wr(OFFSET_CTRL_STS, {30'h3FFFFFFF, ps_seq[i]});
			if (ps_seq[i] inside {2'h0, 2'h3}) ps_exp = ps_seq[i];
			rd(OFFSET_CTRL_STS, {30'h0, ps_exp});
			chk(power_state, {30'h0, ps_exp});
		end
		wr(12'h078, 32'hFFFFFFFF);
		rd(12'h078, 32'h0);
		rd(OFFSET_CTRL_STS, 32'h0);
		for (int c = 0; c < 2; c++) begin
			@(posedge clk);
			in_d3_cold <= c[0];
			event_in_valid <= 1'b1;
			@(posedge clk);
			event_in_valid <= 1'b0;
			#1;
			chk(event_fwd_valid, c == 0);
			@(posedge clk);
			#1;
			chk(event_fwd_valid, 32'h0);
		end
		end_sim();
	end
endmodule
`default_nettype wire
